// ==== shared/cvsd_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the transcoder control
`ifndef CVSD_REGS_SVH
`define CVSD_REGS_SVH

// Register byte offsets
`define REG_CONTROL      5'h00
`define REG_STATUS       5'h04
`define REG_SAMPLE_IN    5'h08
`define REG_SAMPLE_OUT   5'h0c
`define REG_CODED_IN     5'h10
`define REG_CODED_OUT    5'h14

// Control field reset value
`define CONTROL_RESET    8'h00

// Status field positions
`define ST_IN_NEAR_BIT   0
`define ST_IN_EMPTY_BIT  1
`define ST_OUT_NEAR_BIT  2
`define ST_OUT_FULL_BIT  3
`define ST_SOUT_FULL_BIT 4
`define ST_SIN_EMPTY_BIT 5
`define ST_STALL_BIT     6
`define ST_IN_CNT_LSB    8
`define ST_OUT_CNT_LSB   16

// Coded FIFO sizing and warning levels
`define FIFO_DEPTH       8
`define WARN_LEVEL       5
`define NEAR_LEVEL       3
`define CHECKERBOARD     16'haaaa

// Pacing
`define CLK_PERIOD_NS    4
`define SAMPLE_PERIOD_NS 125000
`define WORD_PERIOD_NS   250000
`define FIXED_SAMPLE_CYC (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)
`define SAMPLES_PER_WORD (`WORD_PERIOD_NS / `SAMPLE_PERIOD_NS)
`define FREE_SAMPLE_CYC  250
`define FREE_WORD_CYC    500

`endif

// ==== shared/cvsd_pkg.sv ====
// Types shared by the transcoder control logic
package cvsd_pkg;

	// Pacing state, one-hot
	typedef enum logic [1:0] {
		ST_COUNT = 2'b01,
		ST_HOLD  = 2'b10
	} step_e;

	// Control register layout, bit 0 last
	typedef struct packed {
		logic fifo_error_irq_en;
		logic fifo_warn_irq_en;
		logic sample_irq_en;
		logic sample_out_dma_en;
		logic sample_in_dma_en;
		logic coded_out_dma_en;
		logic coded_in_dma_en;
		logic free_run_select;
	} transcoder_control_s;

endpackage

// ==== hw/cvsd_pcm_transcoder_control.sv ====
// Control, flag, interrupt and DMA request logic of one CVSD/PCM transcoder channel
`timescale 1ns/100ps
`include "cvsd_regs.svh"

module cvsd_pcm_transcoder_control
	import cvsd_pkg::*;
#(
	parameter int DEPTH     = `FIFO_DEPTH,
	parameter int CNT_W     = 16,
	parameter int FIXED_CYC = `FIXED_SAMPLE_CYC,
	parameter int FREE_CYC  = `FREE_SAMPLE_CYC
) (
	// Clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        SYS_RST_I,
	// Avalon-MM slave
	input  wire logic [4:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// Arithmetic core
	input  wire logic [15:0] CORE_PCM_I,
	input  wire logic [15:0] CORE_CODED_I,
	output logic      [15:0] CORE_PCM_O,
	output logic      [15:0] CORE_CODED_O,
	output logic             CORE_STEP_O,
	output logic             CORE_WORD_O,
	// DMA requests and acknowledges
	input  wire logic        SAMPLE_IN_DACK_I,
	input  wire logic        SAMPLE_OUT_DACK_I,
	input  wire logic        CODED_IN_DACK_I,
	input  wire logic        CODED_OUT_DACK_I,
	output logic             SAMPLE_IN_DREQ_O,
	output logic             SAMPLE_OUT_DREQ_O,
	output logic             CODED_IN_DREQ_O,
	output logic             CODED_OUT_DREQ_O,
	// Interrupt
	output logic             IRQ_O
);

	// Pointer width, and a count wide enough to hold DEPTH so that a full FIFO is distinct from empty
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// Whole state of the block
	typedef struct packed {
		transcoder_control_s         ctrl_r;
		step_e                       step_r;
		logic [CNT_W-1:0]            tick_r;
		logic                        phase_r;
		logic [15:0]                 sample_in_r;
		logic                        sample_in_empty_r;
		logic [15:0]                 sample_out_r;
		logic                        sample_out_full_r;
		logic [DEPTH-1:0][15:0]      in_mem_r;
		logic [PW-1:0]               in_wp_r;
		logic [PW-1:0]               in_rp_r;
		logic [CW-1:0]               in_cnt_r;
		logic [DEPTH-1:0][15:0]      out_mem_r;
		logic [PW-1:0]               out_wp_r;
		logic [PW-1:0]               out_rp_r;
		logic [CW-1:0]               out_cnt_r;
		logic                        si_req_r;
		logic                        so_req_r;
		logic                        ci_req_r;
		logic                        co_req_r;
		logic                        ci_primed_r;
		logic                        wait_r;
		logic [31:0]                 rdata_r;
		logic [15:0]                 core_pcm_r;
		logic [15:0]                 core_coded_r;
		logic                        core_step_r;
		logic                        core_word_r;
		logic                        irq_r;
	} state_s;

	// Registered state and the value it takes at the next edge
	state_s r;
	state_s r_nxt;

	// Pointer advance with wrap at the FIFO depth
	// DEPTH need not be a power of two, so the wrap is explicit
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
			ptr_inc = '0;
		else
			ptr_inc = p + PW'(1);
	endfunction

	// Status word built from a state copy
	// FIFO flags derive from the counts, so they cannot drift from the FIFO contents
	function automatic logic [31:0] status_word(input state_s s);
		logic [31:0] w;
		w = '0;
		w[`ST_IN_NEAR_BIT]          = (s.in_cnt_r == CW'(`NEAR_LEVEL));
		w[`ST_IN_EMPTY_BIT]         = (s.in_cnt_r == '0);
		w[`ST_OUT_NEAR_BIT]         = (s.out_cnt_r >= CW'(`WARN_LEVEL));
		w[`ST_OUT_FULL_BIT]         = (s.out_cnt_r == CW'(DEPTH));
		w[`ST_SOUT_FULL_BIT]        = s.sample_out_full_r;
		w[`ST_SIN_EMPTY_BIT]        = s.sample_in_empty_r;
		w[`ST_STALL_BIT]            = (s.step_r == ST_HOLD);
		w[`ST_IN_CNT_LSB +: CW]     = s.in_cnt_r;
		w[`ST_OUT_CNT_LSB +: CW]    = s.out_cnt_r;
		status_word = w;
	endfunction

	// Helpers of the next-state process, all assigned at its top
	logic              bus_req;
	logic              bus_rd;
	logic              bus_wr;
	logic              free_run;
	logic              stall;
	logic              do_step;
	logic              in_push;
	logic              in_pop;
	logic              out_push;
	logic              out_pop;
	logic [CNT_W-1:0]  reload;
	logic [31:0]       st;

	// Next-state logic
	always_comb begin
		// Hold everything, drop the one-cycle pulses, waitrequest idles high
		r_nxt = r;
		r_nxt.wait_r      = 1'b1;
		r_nxt.core_step_r = 1'b0;
		r_nxt.core_word_r = 1'b0;
		// Events of this cycle, raised below
		in_push  = 1'b0;
		in_pop   = 1'b0;
		out_push = 1'b0;
		out_pop  = 1'b0;
		do_step  = 1'b0;
		st       = status_word(r);

		// Read side effects land at the answer edge, together with the data they return;
		// a step or push in that same cycle then sets its flag again and nothing is lost
		bus_req  = AVS_READ_I | AVS_WRITE_I;
		bus_rd   = AVS_READ_I & r.wait_r;
		// Writes land at the edge where waitrequest is low; byte lane zero must be enabled
		bus_wr   = AVS_WRITE_I & ~r.wait_r & AVS_BYTEENABLE_I[0];

		// Free-run only with both coded DMA channels enabled
		// A pending coded request in free-run holds the next step until it is acknowledged
		free_run = r.ctrl_r.free_run_select & r.ctrl_r.coded_in_dma_en
			& r.ctrl_r.coded_out_dma_en;
		stall    = free_run & (r.ci_req_r | r.co_req_r);
		reload   = free_run ? CNT_W'(FREE_CYC - 1) : CNT_W'(FIXED_CYC - 1);

		// Bus answer: one wait cycle, then data stands with waitrequest low
		if (bus_req && r.wait_r) begin
			r_nxt.wait_r = 1'b0;
			case (AVS_ADDRESS_I)
				`REG_CONTROL:    r_nxt.rdata_r = {24'h000000, r.ctrl_r};
				`REG_STATUS:     r_nxt.rdata_r = st;
				`REG_SAMPLE_IN:  r_nxt.rdata_r = {16'h0000, r.sample_in_r};
				`REG_SAMPLE_OUT: r_nxt.rdata_r = {16'h0000, r.sample_out_r};
				// An empty output FIFO reads as zero and pops nothing
				`REG_CODED_OUT:  r_nxt.rdata_r = (r.out_cnt_r == '0) ? 32'h00000000 :
					{16'h0000, r.out_mem_r[r.out_rp_r]};
				default:         r_nxt.rdata_r = 32'h00000000;
			endcase
		end

		// Bus write side effects
		if (bus_wr) begin
			case (AVS_ADDRESS_I)
				`REG_CONTROL: begin
					r_nxt.ctrl_r = transcoder_control_s'(AVS_WRITEDATA_I[7:0]);
				end
				`REG_SAMPLE_IN: begin
					r_nxt.sample_in_r       = AVS_WRITEDATA_I[15:0];
					r_nxt.sample_in_empty_r = 1'b0;
				end
				`REG_CODED_IN: begin
					in_push = (r.in_cnt_r != CW'(DEPTH));
				end
				default: begin
				end
			endcase
		end

		// Bus read side effects, taken in the cycle the answer is registered
		if (bus_rd) begin
			case (AVS_ADDRESS_I)
				`REG_SAMPLE_OUT: r_nxt.sample_out_full_r = 1'b0;
				`REG_CODED_OUT:  out_pop = (r.out_cnt_r != '0);
				default: begin
				end
			endcase
		end

		// Acknowledges clear requests before new events can set them again
		// so an event in the same cycle as its acknowledge keeps the request up
		if (SAMPLE_IN_DACK_I)
			r_nxt.si_req_r = 1'b0;
		if (SAMPLE_OUT_DACK_I)
			r_nxt.so_req_r = 1'b0;
		if (CODED_IN_DACK_I)
			r_nxt.ci_req_r = 1'b0;
		if (CODED_OUT_DACK_I)
			r_nxt.co_req_r = 1'b0;

		// Pacing of transcoding cycles
		// The counter expires at zero and reloads with the period of the current mode
		case (r.step_r)
			ST_COUNT: begin
				if (r.tick_r == '0) begin
					r_nxt.tick_r = reload;
					if (stall)
						r_nxt.step_r = ST_HOLD;
					else
						do_step = 1'b1;
				end else begin
					r_nxt.tick_r = r.tick_r - CNT_W'(1);
				end
			end
			ST_HOLD: begin
				// Resume in the cycle after both coded requests are acknowledged
				if (!stall) begin
					do_step      = 1'b1;
					r_nxt.step_r = ST_COUNT;
					r_nxt.tick_r = reload;
				end
			end
			default: begin
				r_nxt.step_r = ST_COUNT;
				r_nxt.tick_r = reload;
			end
		endcase

		// One sample step of the core
		if (do_step) begin
			r_nxt.core_step_r       = 1'b1;
			r_nxt.core_pcm_r        = r.sample_in_r;
			r_nxt.sample_in_empty_r = 1'b1;
			r_nxt.sample_out_r      = CORE_PCM_I;
			r_nxt.sample_out_full_r = 1'b1;
			// Sample-path requests; a set in the same cycle as an acknowledge wins
			if (r.ctrl_r.sample_in_dma_en)
				r_nxt.si_req_r = 1'b1;
			if (r.ctrl_r.sample_out_dma_en)
				r_nxt.so_req_r = 1'b1;
			r_nxt.phase_r = ~r.phase_r;
			// Every second sample step moves one coded word each way
			if (r.phase_r) begin
				r_nxt.core_word_r = 1'b1;
				// An empty input FIFO yields the checkerboard instead of stale data
				if (r.in_cnt_r == '0) begin
					r_nxt.core_coded_r = `CHECKERBOARD;
				end else begin
					r_nxt.core_coded_r = r.in_mem_r[r.in_rp_r];
					in_pop = 1'b1;
				end
				if (r.ctrl_r.coded_in_dma_en)
					r_nxt.ci_req_r = 1'b1;
				// A read that frees a slot in this cycle makes room for the word
				if (r.out_cnt_r != CW'(DEPTH) || out_pop) begin
					out_push = 1'b1;
					if (r.ctrl_r.coded_out_dma_en)
						r_nxt.co_req_r = 1'b1;
				end // Otherwise the word is dropped
			end
		end

		// Input FIFO update
		// A bus push and a core pop in one cycle leave the count unchanged
		if (in_push) begin
			r_nxt.in_mem_r[r.in_wp_r] = AVS_WRITEDATA_I[15:0];
			r_nxt.in_wp_r             = ptr_inc(r.in_wp_r);
		end
		if (in_pop)
			r_nxt.in_rp_r = ptr_inc(r.in_rp_r);
		if (in_push && !in_pop)
			r_nxt.in_cnt_r = r.in_cnt_r + CW'(1);
		else if (in_pop && !in_push)
			r_nxt.in_cnt_r = r.in_cnt_r - CW'(1);

		// Output FIFO update
		// A core push and a bus pop in one cycle leave the count unchanged
		if (out_push) begin
			r_nxt.out_mem_r[r.out_wp_r] = CORE_CODED_I;
			r_nxt.out_wp_r              = ptr_inc(r.out_wp_r);
		end
		if (out_pop)
			r_nxt.out_rp_r = ptr_inc(r.out_rp_r);
		if (out_push && !out_pop)
			r_nxt.out_cnt_r = r.out_cnt_r + CW'(1);
		else if (out_pop && !out_push)
			r_nxt.out_cnt_r = r.out_cnt_r - CW'(1);

		// Single initial coded-in request at low fill, rearmed when disabled
		// Re-arming only on disable lets software restart a stream with one fresh request
		if (!r_nxt.ctrl_r.coded_in_dma_en) begin
			r_nxt.ci_primed_r = 1'b0;
		end else if (!r.ci_primed_r && r_nxt.in_cnt_r <= CW'(`NEAR_LEVEL)) begin
			r_nxt.ci_req_r    = 1'b1;
			r_nxt.ci_primed_r = 1'b1;
		end

		// Interrupt is the OR of every enabled condition on the next state
		// Sample interrupts are levels, cleared by reading or refilling the buffer
		st = status_word(r_nxt);
		r_nxt.irq_r =
			(r_nxt.ctrl_r.sample_irq_en & (st[`ST_SOUT_FULL_BIT] | st[`ST_SIN_EMPTY_BIT]))
			| (r_nxt.ctrl_r.fifo_warn_irq_en
				& (st[`ST_IN_NEAR_BIT] | st[`ST_OUT_NEAR_BIT]))
			| (r_nxt.ctrl_r.fifo_error_irq_en
				& (st[`ST_IN_EMPTY_BIT] | st[`ST_OUT_FULL_BIT]));
	end

	// State register with synchronous reset
	// Control comes out of reset in fixed-rate mode with every enable off
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			r                   <= '0;
			r.ctrl_r            <= transcoder_control_s'(`CONTROL_RESET);
			r.step_r            <= ST_COUNT;
			r.tick_r            <= CNT_W'(FIXED_CYC - 1);
			r.sample_in_empty_r <= 1'b1;
			r.wait_r            <= 1'b1;
		end else begin
			r <= r_nxt;
		end
	end

	// Outputs straight from the state flops
	// Waitrequest idles high, so every access sees exactly one wait cycle
	assign AVS_READDATA_O    = r.rdata_r;
	assign AVS_WAITREQUEST_O = r.wait_r;
	assign CORE_PCM_O        = r.core_pcm_r;
	assign CORE_CODED_O      = r.core_coded_r;
	assign CORE_STEP_O       = r.core_step_r;
	assign CORE_WORD_O       = r.core_word_r;
	assign SAMPLE_IN_DREQ_O  = r.si_req_r;
	assign SAMPLE_OUT_DREQ_O = r.so_req_r;
	assign CODED_IN_DREQ_O   = r.ci_req_r;
	assign CODED_OUT_DREQ_O  = r.co_req_r;
	assign IRQ_O             = r.irq_r;

endmodule

// ==== testbench/cvsd_ctrl_assertions.sv ====
// Concurrent checks on the ports of the transcoder control block
`timescale 1ns/100ps
module cvsd_ctrl_assertions #(
	parameter int FREE_CYC = 250
) (
	// Clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        SYS_RST_I,
	// Bus handshake
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic        AVS_WAITREQUEST_O,
	// Core pacing
	input  wire logic [15:0] CORE_CODED_O,
	input  wire logic        CORE_STEP_O,
	input  wire logic        CORE_WORD_O,
	// DMA
	input  wire logic        SAMPLE_OUT_DACK_I,
	input  wire logic        SAMPLE_OUT_DREQ_O,
	input  wire logic        SAMPLE_IN_DREQ_O
);
	int   gap_r;
	logic last_w_r;
	logic seen_r;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);
	// Cycles since the last step and whether it moved words
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			gap_r <= FREE_CYC;
			last_w_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (CORE_STEP_O) begin
			gap_r <= 0;
			last_w_r <= CORE_WORD_O;
			seen_r <= 1'b1;
		end else if (gap_r < FREE_CYC) begin
			gap_r <= gap_r + 1;
		end
	end
	AST_WAIT_ANSWER: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
		|=> !AVS_WAITREQUEST_O) else $error("access not answered after one wait cycle");
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low for more than one cycle");
	AST_STEP_GAP: assert property (CORE_STEP_O |-> gap_r >= FREE_CYC - 1)
		else $error("steps closer than the free-run period");
	AST_WORD_ALT: assert property (CORE_STEP_O && seen_r |-> CORE_WORD_O != last_w_r)
		else $error("word steps do not alternate");
	AST_CODED_HOLD: assert property ($changed(CORE_CODED_O) |-> CORE_WORD_O)
		else $error("coded word changed outside a word step");
	AST_SOUT_REQ: assert property ($rose(SAMPLE_OUT_DREQ_O)
		|-> CORE_STEP_O || $past(CORE_STEP_O)) else $error("sample-out request without step");
	AST_SIN_REQ: assert property ($rose(SAMPLE_IN_DREQ_O)
		|-> CORE_STEP_O || $past(CORE_STEP_O)) else $error("sample-in request without step");
	AST_DREQ_HOLD: assert property (SAMPLE_OUT_DREQ_O && !SAMPLE_OUT_DACK_I
		|=> SAMPLE_OUT_DREQ_O) else $error("request dropped before acknowledge");
endmodule
bind cvsd_pcm_transcoder_control cvsd_ctrl_assertions #(.FREE_CYC(FREE_CYC)) chk (
	.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .AVS_READ_I(AVS_READ_I),
	.AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.CORE_CODED_O(CORE_CODED_O), .CORE_STEP_O(CORE_STEP_O), .CORE_WORD_O(CORE_WORD_O),
	.SAMPLE_OUT_DACK_I(SAMPLE_OUT_DACK_I), .SAMPLE_OUT_DREQ_O(SAMPLE_OUT_DREQ_O),
	.SAMPLE_IN_DREQ_O(SAMPLE_IN_DREQ_O));

// ==== testbench/dma_partner.sv ====
// Far side model: DMA controller acknowledging requests and core data source
`timescale 1ns/100ps
module dma_partner (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Withholds coded channel service while high
	input  wire logic        hold_i,
	// Core pacing seen from the block
	input  wire logic        step_i,
	input  wire logic        word_i,
	output logic      [15:0] pcm_o   = 16'h0100,
	output logic      [15:0] coded_o = 16'h0c00,
	// Requests {coded out, coded in, sample out, sample in}
	input  wire logic [3:0]  dreq_i,
	output logic      [3:0]  dack_o  = 4'h0
);
	logic [3:0] seen_r = 4'h0;
	// Ack every sample request, and coded ones while hold_i is low, one cycle after seeing it, as a one-cycle pulse
	always @(posedge clk_i) begin
		if (rst_i) begin
			seen_r <= 4'h0;
			dack_o <= 4'h0;
		end else begin
			seen_r <= dreq_i & ~dack_o & {~hold_i, ~hold_i, 2'b11};
			dack_o <= seen_r & dreq_i & ~dack_o;
		end
	end
	// Fresh core results after each step and each word step
	always @(posedge clk_i) begin
		if (step_i) begin
			pcm_o <= pcm_o + 16'h0001;
		end
		if (word_i) begin
			coded_o <= coded_o + 16'h0001;
		end
	end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking testbench of the transcoder control block
`timescale 1ns/100ps
module tb_top;
	localparam int FIX = 40;
	localparam int FRE = 10;
	logic        clk, rst, rd, wr, wq, step, word, irq, hold, bad;
	logic [4:0]  adr;
	logic [31:0] wd, rdata, d;
	logic [15:0] pcm_i, cod_i, pcm_o, cod_o, p;
	logic [3:0]  dack, dreq;
	int          n_fail, checks_done, c;

	cvsd_pcm_transcoder_control #(.FIXED_CYC(FIX), .FREE_CYC(FRE)) uut (
		.CLK_SYS_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wd),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq), .CORE_PCM_I(pcm_i),
		.CORE_CODED_I(cod_i), .CORE_PCM_O(pcm_o), .CORE_CODED_O(cod_o), .CORE_STEP_O(step),
		.CORE_WORD_O(word), .SAMPLE_IN_DACK_I(dack[0]), .SAMPLE_OUT_DACK_I(dack[1]),
		.CODED_IN_DACK_I(dack[2]), .CODED_OUT_DACK_I(dack[3]), .SAMPLE_IN_DREQ_O(dreq[0]),
		.SAMPLE_OUT_DREQ_O(dreq[1]), .CODED_IN_DREQ_O(dreq[2]), .CODED_OUT_DREQ_O(dreq[3]),
		.IRQ_O(irq));
	dma_partner far (.clk_i(clk), .rst_i(rst), .hold_i(hold), .step_i(step), .word_i(word),
		.pcm_o(pcm_i), .coded_o(cod_i), .dreq_i(dreq), .dack_o(dack));

	// Counts, verdict and end of run
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Compare one value
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	// One bus access, held until waitrequest is low at an edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
		int   n;
		logic q;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= v;
		wr <= w;
		rd <= !w;
		do begin
			@(negedge clk);
			q = wq;
			d = rdata;
			@(posedge clk);
			n++;
			if (n > 20) begin
				n_fail++;
				finish_test();
			end
		end while (q !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Wait for the next core step, counting cycles
	task automatic wait_step(input int lim);
		c = 0;
		do begin
			@(negedge clk);
			c++;
			if (c > lim) begin
				n_fail++;
				finish_test();
			end
		end while (step !== 1'b1);
	endtask
	// Reset values and an unmapped address
	task automatic t_reset();
		bus(1'b0, 5'h00, 32'h0);
		check(d, 32'h0);
		bus(1'b0, 5'h04, 32'h0);
		check(d & 32'h000f_0f0f, 32'h0000_0002);
		bus(1'b0, 5'h18, 32'h0);
		check(d, 32'h0);
	endtask
	// Fill the coded input FIFO just after a word step, one word too many
	task automatic t_fill();
		do wait_step(100); while (word !== 1'b1);
		for (int k = 0; k < 9; k++) begin
			bus(1'b1, 5'h10, 32'h1000 + k);
			if (k == 2) begin
				bus(1'b0, 5'h04, 32'h0);
				check(d & 32'h0000_0f03, 32'h0000_0301);
			end
		end
		bus(1'b0, 5'h04, 32'h0);
		check(d & 32'h0000_0f03, 32'h0000_0800);
	endtask
	// Core drains in order, then gets the checkerboard; output FIFO fills
	task automatic t_drain();
		for (int k = 0; k < 9; k++) begin
			wait_step(100);
			if (word !== 1'b1) begin
				wait_step(100);
				check(c, FIX);
			end
			check({16'h0, cod_o}, k < 8 ? 32'h1000 + k : 32'haaaa);
		end
		bus(1'b0, 5'h04, 32'h0);
		check(d & 32'h000f_000e, 32'h0008_000e);
		bus(1'b0, 5'h14, 32'h0);
		check(d, 32'h0000_0c00);
	endtask
	// Each interrupt enable against standing flags, then none
	task automatic t_irq();
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 5'h00, k < 3 ? 32'h80 >> k : 32'h0);
			repeat (2) @(negedge clk);
			check(irq, k < 3);
		end
	endtask
	// Sample overwrite, reuse of a stale input and the sample interrupt
	task automatic t_sample();
		bus(1'b1, 5'h00, 32'h20); // Sample interrupt alone, no DMA enable
		bus(1'b1, 5'h08, 32'h1234);
		wait_step(100);
		check(pcm_o, 16'h1234);
		wait_step(100);
		check(pcm_o, 16'h1234);
		p = pcm_i;
		bus(1'b0, 5'h0c, 32'h0);
		check(d, {16'h0, p});
		bus(1'b1, 5'h08, 32'h5678);
		repeat (2) @(negedge clk);
		check(irq, 1'b0);
		wait_step(100);
		@(negedge clk);
		check(irq, 1'b1);
	endtask
	// Free-run pace, DMA requests, stall and resume
	task automatic t_dma();
		// Free one output slot so the next word step pushes and requests
		bus(1'b0, 5'h14, 32'h0);
		check(d, 32'h0000_0c01);
		bus(1'b1, 5'h00, 32'h1f); // DMA enables and free-run select, no interrupt enable
		wait_step(100);
		check(dreq, 4'hf);
		wait_step(30);
		check(c, FRE);
		@(negedge clk);
		check(dreq[1:0], 2'b11);
		@(posedge clk);
		hold <= 1'b1;
		d = 32'h0;
		for (int k = 0; k < 20 && d[6] !== 1'b1; k++) bus(1'b0, 5'h04, 32'h0);
		check(d[6], 1'b1);
		bad = 1'b0;
		repeat (40) begin
			@(negedge clk);
			bad = bad | step;
		end
		check(bad, 1'b0);
		@(posedge clk);
		hold <= 1'b0;
		wait_step(10);
		wait_step(30);
		check(c, FRE);
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk; // Pace source; FIX scales the fixed-rate period
	end
	// Reset, then the scenarios
	initial begin
		n_fail = 0;
		checks_done = 0;
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		hold = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fill();
		t_drain();
		t_irq();
		t_sample();
		t_dma();
		finish_test();
	end
endmodule
